// *** logic/adcr_defines.vh ***
/*
 Constants of the serial readout block: widths, timing and state codes.
 Assumes it is included by bare name from the design files and holds definitions only.
*/
`ifndef ADCR_DEFINES_VH
`define ADCR_DEFINES_VH

// Result word width and depth of the result FIFO.
`define ADCR_DATA_W 16
`define ADCR_FIFO_DEPTH 8
`define ADCR_FIFO_AW 3

// System clock rate in MHz and the longest conversion time in ns.
`define ADCR_CLK_MHZ 200
`define ADCR_TCONV_NS 1000
// Whole cycles, rounded up, so the host's longest-time budget is never undercut.
`define ADCR_TCONV_CYC ((`ADCR_TCONV_NS * `ADCR_CLK_MHZ + 999) / 1000)
`define ADCR_TMR_W 12

// Falling edges of the serial clock in one chip-select read.
`define ADCR_LEN_PLAIN 5'h10
`define ADCR_LEN_BUSY 5'h11

// State codes.
`define ADCR_ST_IDLE 3'h0
`define ADCR_ST_CONV 3'h1
`define ADCR_ST_WAIT 3'h2
`define ADCR_ST_SHIFT 3'h3
`define ADCR_ST_DAISY 3'h4

`endif

// *** logic/adcr_fifo.v ***
/*
 Small synchronous FIFO with valid and ready on both sides.
 Assumes one clock and an active-low asynchronous reset; DEPTH is a power of two.
*/
`timescale 1ns/1ps
module adcr_fifo #(
	parameter WIDTH = 16,
	parameter DEPTH = 8,
	parameter AW = 3
) (
	input wire clock,
	input wire resetn,
	input wire [WIDTH-1:0] in_data,
	input wire in_valid,
	output wire in_ready,
	output wire [WIDTH-1:0] out_data,
	output wire out_valid,
	input wire out_ready
);
	reg [WIDTH-1:0] mem_ff [0:DEPTH-1];
	reg [AW-1:0] wr_ptr_ff;
	reg [AW-1:0] rd_ptr_ff;
	reg [AW:0] count_ff;
	reg [WIDTH-1:0] head_ff;
	wire push;
	wire pop;
	wire [AW-1:0] nxt_rd_ptr;

	localparam [AW:0] FULL_COUNT = DEPTH;

	assign in_ready = (count_ff != FULL_COUNT);
	assign out_valid = (count_ff != {(AW+1){1'b0}});
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	assign nxt_rd_ptr = pop ? rd_ptr_ff + {{(AW-1){1'b0}}, 1'b1} : rd_ptr_ff;
	assign out_data = head_ff;

	always @(posedge clock) begin
		if (push) begin
			mem_ff[wr_ptr_ff] <= in_data;
		end
	end

	// The head word is registered; a push into an empty or just-drained FIFO bypasses.
	always @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			wr_ptr_ff <= {AW{1'b0}};
			rd_ptr_ff <= {AW{1'b0}};
			count_ff <= {(AW+1){1'b0}};
			head_ff <= {WIDTH{1'b0}};
		end else begin
			if (push) begin
				wr_ptr_ff <= wr_ptr_ff + {{(AW-1){1'b0}}, 1'b1};
			end
			rd_ptr_ff <= nxt_rd_ptr;
			if (push && !pop) begin
				count_ff <= count_ff + {{AW{1'b0}}, 1'b1};
			end else if (pop && !push) begin
				count_ff <= count_ff - {{AW{1'b0}}, 1'b1};
			end
			if (push && (nxt_rd_ptr == wr_ptr_ff)) begin
				head_ff <= in_data;
			end else begin
				head_ff <= mem_ff[nxt_rd_ptr];
			end
		end
	end
endmodule // adcr_fifo

// *** logic/adcr_readout.v ***
/*
 Serial result readout and conversion trigger of a 16-bit converter, covering the
 4-wire chip-select options and the daisy-chain options, each with or without a busy bit.
 Assumes the pins convert_start, serial_in and sclk arrive asynchronously and that the
 converter core pushes one two's complement result word per conversion into the FIFO.
*/
// Operation
// RL1 - select high at start: chip-select, release output
// RL2 - host holds convert_start high through read
// RL3 - internal timer ends conversion regardless of select
// RL4 - select high at end: no busy bit
// RL5 - select fall drives MSB, then shift
// RL6 - release after sixteenth fall or select rise
// RL7 - bits stand across both clock edges
// RL8 - host selects next device after release
// RL9 - host never lets both lines low
// RL10 - select low at end: busy bit
// RL11 - busy bit low, then data MSB first
// RL12 - busy release after seventeenth fall or rise
// RL13 - input low at start: daisy-chain mode
// RL14 - both lines low: drive output low
// RL15 - clock high at start: chain busy bit
// RL16 - chain conversion ignores serial clock activity
// RL17 - chain end: load word, show MSB
// RL18 - each fall shifts input in, next out
// RL19 - host gives sixteen falls per device
// RL20 - chain busy: drive output high first
// RL21 - host expects busy, then last device
// RL22 - upstream busy bits never shifted in
// RL23 - results are two's complement codes
// RL24 - mode chosen anew at every start; the code ignores a start that comes during a conversion
`timescale 1ns/1ps
`include "adcr_defines.vh"
module adcr_readout #(
	parameter DATA_W = `ADCR_DATA_W,
	parameter FIFO_DEPTH = `ADCR_FIFO_DEPTH,
	parameter FIFO_AW = `ADCR_FIFO_AW,
	parameter CONV_CYCLES = `ADCR_TCONV_CYC
) (
	input wire clock,
	input wire resetn,
	input wire convert_start,
	input wire serial_in,
	input wire sclk,
	input wire [DATA_W-1:0] result_data,
	input wire result_valid,
	output wire result_ready,
	output wire sample_strobe,
	output wire converting,
	output wire serial_out,
	output wire serial_out_oe
);
	localparam TW = `ADCR_TMR_W;
	localparam [TW-1:0] CONV_LOAD = CONV_CYCLES - 1;

	reg [2:0] sync1_ff;
	reg [2:0] sync2_ff;
	reg [2:0] sync3_ff;
	wire [2:0] pin_in;
	wire cs_lvl;
	wire cs_rise;
	wire din_lvl;
	wire din_rise;
	wire din_fall;
	wire sck_lvl;
	wire sck_fall;

	reg [2:0] state_ff;
	reg [2:0] nxt_state;
	reg cs_mode_ff;
	reg nxt_cs_mode;
	reg chain_busy_ff;
	reg nxt_chain_busy;
	reg busy_ff;
	reg nxt_busy;
	reg [TW-1:0] tmr_ff;
	reg [TW-1:0] nxt_tmr;
	reg [DATA_W-1:0] shreg_ff;
	reg [DATA_W-1:0] nxt_shreg;
	reg [4:0] cnt_ff;
	reg [4:0] nxt_cnt;
	reg dout_ff;
	reg nxt_dout;
	reg oe_ff;
	reg nxt_oe;
	reg strobe_ff;
	reg nxt_strobe;
	reg pop;

	wire [DATA_W-1:0] fifo_data;
	wire fifo_valid;
	wire [4:0] cnt_inc;
	wire [4:0] read_len;

	assign pin_in = {sclk, serial_in, convert_start};

	// Three stages: two to settle the pin, the third only to find edges.
	// The select bit resets high, its idle level, so no false rise follows reset.
	always @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			sync1_ff <= 3'h2;
			sync2_ff <= 3'h2;
			sync3_ff <= 3'h2;
		end else begin
			sync1_ff <= pin_in;
			sync2_ff <= sync1_ff;
			sync3_ff <= sync2_ff;
		end
	end

	assign cs_lvl = sync2_ff[0];
	assign cs_rise = sync2_ff[0] && !sync3_ff[0];
	assign din_lvl = sync2_ff[1];
	assign din_rise = sync2_ff[1] && !sync3_ff[1];
	assign din_fall = !sync2_ff[1] && sync3_ff[1];
	assign sck_lvl = sync2_ff[2];
	assign sck_fall = !sync2_ff[2] && sync3_ff[2];

	// The core keeps its results here; a full FIFO back-pressures the core.
	adcr_fifo #(
		.WIDTH(DATA_W),
		.DEPTH(FIFO_DEPTH),
		.AW(FIFO_AW)
	) u_fifo (
		.clock(clock),
		.resetn(resetn),
		.in_data(result_data),
		.in_valid(result_valid),
		.in_ready(result_ready),
		.out_data(fifo_data),
		.out_valid(fifo_valid),
		.out_ready(pop)
	);

	assign cnt_inc = cnt_ff + 5'h01;
	assign read_len = busy_ff ? `ADCR_LEN_BUSY : `ADCR_LEN_PLAIN;

	always @* begin
		nxt_state = state_ff;
		nxt_cs_mode = cs_mode_ff;
		nxt_chain_busy = chain_busy_ff;
		nxt_busy = busy_ff;
		nxt_tmr = tmr_ff;
		nxt_shreg = shreg_ff;
		nxt_cnt = cnt_ff;
		nxt_dout = dout_ff;
		nxt_oe = oe_ff;
		nxt_strobe = 1'b0;
		pop = 1'b0;
		case (state_ff)
			`ADCR_ST_CONV: begin
				nxt_oe = 1'b0;
				// RL3 internal timer only
				if (tmr_ff != {TW{1'b0}}) begin
					nxt_tmr = tmr_ff - {{(TW-1){1'b0}}, 1'b1};
				end else if (fifo_valid) begin
					pop = 1'b1;
					// RL23 code passed unchanged
					nxt_shreg = fifo_data;
					nxt_cnt = 5'h00;
					if (cs_mode_ff) begin
						// RL4 select high, no busy
						nxt_busy = !din_lvl;
						if (!din_lvl) begin
							// RL10 select low, busy
							// RL11 busy bit low
							nxt_state = `ADCR_ST_SHIFT;
							nxt_dout = 1'b0;
							nxt_oe = 1'b1;
						end else begin
							nxt_state = `ADCR_ST_WAIT;
						end
					end else begin
						// RL17 load and show MSB
						// RL20 busy drives high
						nxt_state = `ADCR_ST_DAISY;
						nxt_busy = chain_busy_ff;
						nxt_dout = chain_busy_ff ? 1'b1 : fifo_data[DATA_W-1];
						nxt_oe = 1'b1;
					end
				end
			end
			`ADCR_ST_WAIT: begin
				// RL5 select fall shows MSB
				if (din_fall) begin
					nxt_state = `ADCR_ST_SHIFT;
					nxt_dout = shreg_ff[DATA_W-1];
					nxt_oe = 1'b1;
				end
			end
			`ADCR_ST_SHIFT: begin
				// RL6 plain read release
				// RL12 busy read release
				if (din_rise) begin
					nxt_state = `ADCR_ST_IDLE;
					nxt_oe = 1'b0;
				end else if (sck_fall) begin
					nxt_cnt = cnt_inc;
					if (cnt_inc == read_len) begin
						nxt_state = `ADCR_ST_IDLE;
						nxt_oe = 1'b0;
					end else if (busy_ff && (cnt_ff == 5'h00)) begin
						nxt_dout = shreg_ff[DATA_W-1];
					end else begin
						// RL7 bit held between falls
						nxt_shreg = {shreg_ff[DATA_W-2:0], 1'b0};
						nxt_dout = shreg_ff[DATA_W-2];
					end
				end
			end
			`ADCR_ST_DAISY: begin
				if (!cs_lvl) begin
					nxt_state = `ADCR_ST_IDLE;
					nxt_oe = 1'b0;
				end else if (sck_fall) begin
					if (busy_ff) begin
						// RL22 upstream busy dropped
						nxt_busy = 1'b0;
						nxt_dout = shreg_ff[DATA_W-1];
					end else begin
						// RL18 shift in, next out
						nxt_shreg = {shreg_ff[DATA_W-2:0], din_lvl};
						nxt_dout = shreg_ff[DATA_W-2];
					end
				end
			end
			`ADCR_ST_IDLE: begin
				nxt_oe = 1'b0;
			end
			default: begin
				nxt_state = `ADCR_ST_IDLE;
				nxt_oe = 1'b0;
			end
		endcase
		// A start pulse during a running conversion is ignored; the core is busy sampling.
		if (cs_rise && (state_ff != `ADCR_ST_CONV)) begin
			// RL24 mode chosen anew
			// RL1 chip-select when input high
			// RL13 daisy when input low
			// RL15 clock level picks busy
			nxt_cs_mode = din_lvl;
			nxt_chain_busy = sck_lvl;
			nxt_busy = 1'b0;
			nxt_tmr = CONV_LOAD;
			nxt_state = `ADCR_ST_CONV;
			nxt_oe = 1'b0;
			nxt_strobe = 1'b1;
		end
		// RL14 both low drives low
		if (!cs_lvl && !din_lvl) begin
			nxt_dout = 1'b0;
			nxt_oe = 1'b1;
		end
	end

	always @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			state_ff <= `ADCR_ST_IDLE;
			cs_mode_ff <= 1'b1;
			chain_busy_ff <= 1'b0;
			busy_ff <= 1'b0;
			tmr_ff <= {TW{1'b0}};
			shreg_ff <= {DATA_W{1'b0}};
			cnt_ff <= 5'h00;
			dout_ff <= 1'b0;
			oe_ff <= 1'b0;
			strobe_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			cs_mode_ff <= nxt_cs_mode;
			chain_busy_ff <= nxt_chain_busy;
			busy_ff <= nxt_busy;
			tmr_ff <= nxt_tmr;
			shreg_ff <= nxt_shreg;
			cnt_ff <= nxt_cnt;
			dout_ff <= nxt_dout;
			oe_ff <= nxt_oe;
			strobe_ff <= nxt_strobe;
		end
	end

	assign sample_strobe = strobe_ff;
	assign converting = (state_ff == `ADCR_ST_CONV);
	assign serial_out = dout_ff;
	assign serial_out_oe = oe_ff;
endmodule // adcr_readout

// *** dv/adcr_checker.sv ***
/*
 Pin checker for the serial readout, bound to its top module.
 Assumes the host holds the mode pins steady around each start edge.
*/
`timescale 1ns/1ps
module adcr_checker #(
	parameter int CONV_CYCLES = 200
) (
	input wire logic clock,
	input wire logic resetn,
	input wire logic convert_start,
	input wire logic serial_in,
	input wire logic sclk,
	input wire logic [15:0] result_data,
	input wire logic result_valid,
	input wire logic result_ready,
	input wire logic sample_strobe,
	input wire logic converting,
	input wire logic serial_out,
	input wire logic serial_out_oe
);
	logic cs_mode_ff, busy_mode_ff, sclk_d_ff;
	logic [2:0] fall_age_ff;
	default clocking @(posedge clock); endclocking
	default disable iff (!resetn);
	// The mode is latched at the strobe; the pins stay put long enough around it.
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			cs_mode_ff <= 1'b1;
			busy_mode_ff <= 1'b0;
			sclk_d_ff <= 1'b0;
			fall_age_ff <= 3'h7;
		end else begin
			sclk_d_ff <= sclk;
			if (sample_strobe) begin
				cs_mode_ff <= serial_in;
				busy_mode_ff <= sclk;
			end
			if (sclk_d_ff && !sclk) begin
				fall_age_ff <= 3'h0;
			end else if (fall_age_ff != 3'h7) begin
				fall_age_ff <= fall_age_ff + 3'h1;
			end
		end
	end
	AST_START: assert property ($rose(converting) |-> sample_strobe && !serial_out_oe)
		else $error("start");
	AST_CONV: assert property ($rose(converting) |-> converting[*8] ##[0:900] !converting)
		else $error("conv");
	AST_BOTHLOW: assert property ((!convert_start && !serial_in)[*4] |=> serial_out_oe && !serial_out)
		else $error("both low");
	AST_STAND: assert property (serial_out_oe && $past(serial_out_oe) && $changed(serial_out)
		&& convert_start |-> fall_age_ff < 3'h6)
		else $error("stand");
	AST_CSREL: assert property ((cs_mode_ff && !converting && serial_in)[*4] |-> !serial_out_oe)
		else $error("cs rel");
	AST_CSBUSY: assert property (cs_mode_ff && $fell(converting) && !serial_in
		|-> ##[0:1] serial_out_oe && !serial_out)
		else $error("cs busy");
	AST_CSNOBUSY: assert property (cs_mode_ff && $fell(converting) && serial_in
		|-> !serial_out_oe[*2])
		else $error("cs nobusy");
	AST_DAISY: assert property (!cs_mode_ff && $fell(converting)
		|-> ##[0:1] serial_out_oe && (serial_out || !busy_mode_ff))
		else $error("daisy");
	cover property (cs_mode_ff && $fell(converting) && !serial_in);
	cover property (!cs_mode_ff && busy_mode_ff && $fell(converting));
	cover property (result_valid && !result_ready);
endmodule // adcr_checker
bind adcr_readout adcr_checker #(.CONV_CYCLES(CONV_CYCLES)) chk_u (.clock(clock),
	.resetn(resetn), .convert_start(convert_start), .serial_in(serial_in), .sclk(sclk),
	.result_data(result_data), .result_valid(result_valid), .result_ready(result_ready),
	.sample_strobe(sample_strobe), .converting(converting), .serial_out(serial_out),
	.serial_out_oe(serial_out_oe));

// *** dv/adcr_host.sv ***
/*
 Host model: starts conversions and clocks results out with a 48 ns link clock.
 Assumes the readout holds each bit until the next link clock fall.
*/
`timescale 1ns/1ps
module adcr_host (
	output logic convert_start,
	output logic serial_in,
	output logic sclk,
	input wire logic serial_out,
	input wire logic serial_out_oe
);
	initial begin
		convert_start = 1'b0;
		serial_in = 1'b1;
		sclk = 1'b0;
	end
	// Bit 0 of m asks for a busy bit, bit 1 for the chained mode.
	task automatic xfer(input logic [1:0] m, input logic [15:0] up, input int nb,
		output logic [32:0] q, output logic oe_end);
		int idx;
		q = '0;
		serial_in = !m[1];
		sclk = (m == 2'h3);
		#40 convert_start = 1'b1;
		#40 if (m == 2'h1) serial_in = 1'b0;
		#300 if (m == 2'h0) serial_in = 1'b0;
		#40;
		for (int k = 0; k < nb; k++) begin
			idx = k - m[0];
			if (m[1]) serial_in = (idx < 0) ? 1'b1 : (idx < 16) ? up[15-idx] : 1'b0;
			sclk = 1'b1;
			#24 q = {q[31:0], serial_out};
			sclk = 1'b0;
			#24;
		end
		#30 oe_end = serial_out_oe;
		serial_in = !m[1];
		#10 convert_start = 1'b0;
		#40;
	endtask
endmodule // adcr_host

// *** dv/tb.sv ***
/*
 Testbench of the readout: fills the result buffer, then runs every mode.
 Assumes the host model owns the pins and the bench feeds result words.
*/
`timescale 1ns/1ps
`define CHK(nm, e, a) begin n_checks++; if ((a) !== (e)) begin mismatches++; \
	$display("mismatch %s exp %h got %h", nm, e, a); end end
module tb;
	logic clock, resetn, result_valid;
	logic [15:0] result_data;
	logic [1:0] m;
	wire convert_start, serial_in, sclk, result_ready, sample_strobe, converting;
	wire serial_out, serial_out_oe;
	int mismatches, n_checks, cyc, seed, len;
	logic [15:0] fifo_q[$];
	adcr_readout #(.CONV_CYCLES(12)) dut_u (.clock(clock), .resetn(resetn),
		.convert_start(convert_start), .serial_in(serial_in), .sclk(sclk),
		.result_data(result_data), .result_valid(result_valid), .result_ready(result_ready),
		.sample_strobe(sample_strobe), .converting(converting), .serial_out(serial_out),
		.serial_out_oe(serial_out_oe));
	adcr_host host_u (.convert_start(convert_start), .serial_in(serial_in), .sclk(sclk),
		.serial_out(serial_out), .serial_out_oe(serial_out_oe));
	initial begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end
	task automatic finish_test();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	always @(posedge clock) begin
		cyc++;
		if (cyc == 20000) begin
			mismatches++;
			finish_test();
		end
	end
	// Stream that a full read shows, cut to the first nb bits.
	function automatic logic [32:0] exp_bits(input logic [1:0] m, input logic [15:0] d,
		input logic [15:0] up, input int nb);
		logic [32:0] s;
		s = m[1] ? {m[0], d, up} : {17'h0, d};
		return s >> ((m[1] ? 32 : 16) + m[0] - nb);
	endfunction
	task automatic push(input logic [15:0] d);
		@(negedge clock);
		result_valid = 1'b1;
		result_data = d;
		do @(posedge clock); while (result_ready !== 1'b1);
		fifo_q.push_back(d);
		@(negedge clock);
		result_valid = 1'b0;
	endtask
	task automatic op(input logic [1:0] m, input int nb);
		logic [32:0] q;
		logic [15:0] up, d;
		logic oe;
		up = $urandom;
		d = fifo_q.pop_front();
		host_u.xfer(m, up, nb, q, oe);
		`CHK("bits", exp_bits(m, d, up, nb), q)
		`CHK("end_oe", (m[1] || nb < (16 + m[0])), oe)
		`CHK("idle_oe", m[1], serial_out_oe)
		if (m[1]) `CHK("idle_out", 1'b0, serial_out)
	endtask
	initial begin
		resetn = 1'b0;
		result_valid = 1'b0;
		result_data = 16'h0;
		seed = $urandom(75364);
		repeat (6) @(posedge clock);
		@(negedge clock) resetn = 1'b1;
		for (int i = 0; i < 8; i++) push($urandom);
		// A ninth word is offered to the full buffer and must stay out.
		@(negedge clock) result_valid = 1'b1;
		result_data = $urandom;
		repeat (4) @(negedge clock);
		`CHK("full", 1'b0, result_ready)
		result_valid = 1'b0;
		for (int i = 0; i < 24; i++) begin
			if (fifo_q.size() == 0) push($urandom);
			m = (i < 4) ? i[1:0] : 2'($urandom);
			len = (m[1] ? 32 : 16) + m[0];
			op(m, (m[1] || i < 4 || $urandom % 2) ? len : 1 + $urandom % len);
		end
		`CHK("ready", 1'b1, result_ready)
		finish_test();
	end
endmodule // tb
